// ### shared/mlfc_defines.svh
// Offsets, field positions, reset values and timing counts of the lock-fault configuration block
`ifndef MLFC_DEFINES_SVH
`define MLFC_DEFINES_SVH

`define MLFC_ADDR_W 8
`define MLFC_OFF_SETTINGS 8'h92
`define MLFC_OFF_STATUS 8'hA0
`define MLFC_OFF_CLEAR 8'hA4
`define MLFC_OFF_IRQ_EN 8'hA8
`define MLFC_OFF_LIVE 8'hAC
`define MLFC_SETTINGS_RESET 32'h0000_0000
`define MLFC_SETTINGS_WMASK 32'hFFFF_F7FF
`define MLFC_BIT_RSVD_TOP 31
`define MLFC_BIT_OVERSPEED_EN 30
`define MLFC_BIT_BACKEMF_EN 29
`define MLFC_BIT_NO_LOAD_EN 28
`define MLFC_OVERSPEED_HI 27
`define MLFC_OVERSPEED_LO 25
`define MLFC_BACKEMF_HI 24
`define MLFC_BACKEMF_LO 22
`define MLFC_NO_LOAD_HI 21
`define MLFC_NO_LOAD_LO 19
`define MLFC_ILIM_MODE_HI 18
`define MLFC_ILIM_MODE_LO 15
`define MLFC_ILIM_FILT_HI 14
`define MLFC_ILIM_FILT_LO 12
`define MLFC_ILIM_MODE_OFF 4'h8
`define MLFC_CLK_MHZ 40
`define MLFC_FILT_STEP_NS 1000
`define MLFC_CLK_NS 25
`define MLFC_FILT_STEP_CYC (`MLFC_FILT_STEP_NS / `MLFC_CLK_NS)
`define MLFC_FILT_CNT_W 9
`define MLFC_EV_W 4

`endif

// ### shared/mlfc_pkg.sv
// Types of the lock-fault configuration block
package mlfc_pkg;
    typedef enum logic [3:0] {
        MLFC_BRIDGE_TRISTATE = 4'b0001,
        MLFC_BRIDGE_RECIRC = 4'b0010,
        MLFC_BRIDGE_HS_BRAKE = 4'b0100,
        MLFC_BRIDGE_LS_BRAKE = 4'b1000
    } mlfc_bridge_t;
    typedef enum logic [2:0] {
        MLFC_ST_RUN = 3'b001,
        MLFC_ST_FILTER = 3'b010,
        MLFC_ST_LATCHED = 3'b100
    } mlfc_ilim_state_t;
endpackage : mlfc_pkg

// ### hdl/mlfc_detector_gate.sv
// One lock detector qualified by its enable, with a rising-edge event
`timescale 1ns/1ps
`default_nettype none
module mlfc_detector_gate (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic raw_trip,
    output logic fault,
    output logic event_pulse
);
    logic next_fault;

    always_comb begin
        next_fault = enable & raw_trip;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fault <= 1'b0;
        end else begin
            fault <= next_fault;
        end
    end

    assign event_pulse = next_fault & ~fault;

    property p_gate_off;
        @(posedge clk) disable iff (srst) !enable |=> !fault;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("fault while detector disarmed");
endmodule : mlfc_detector_gate
`default_nettype wire

// ### hdl/mlfc_lock_config.sv
// Lock-fault configuration register with detector gating and current-limit lock
//
// Overview of operation
// - Register at byte offset 92h, all bits zero after reset.
// - Every field readable and writable by software, resets to zero.
// - Bit 30 arms or disarms the overspeed lock detector.
// - Bit 29 arms or disarms the back-EMF lock detector.
// - Bit 28 arms or disarms the no-load lock detector.
// - Bits 27-25 pick overspeed trip 130 to 200 percent, 10 percent steps.
// - Bits 24-22 pick back-EMF trip 40 to 70 percent.
// - Bits 21-19 pick no-load current threshold 0.03125 to 0.625 A.
// - Bits 18-15 pick current-limit lock bridge response; code 8 disables.
// - Bits 14-12 pick current-limit filter: none, or 1 to 7 us.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mlfc_defines.svh"
module mlfc_lock_config (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic overspeed_trip,
    input wire logic backemf_trip,
    input wire logic no_load_trip,
    input wire logic current_limit_hit,
    input wire logic current_limit_release,
    output logic [2:0] overspeed_trip_level,
    output logic [2:0] backemf_trip_level,
    output logic [2:0] no_load_current_level,
    output logic overspeed_lock,
    output logic backemf_lock,
    output logic no_load_lock,
    output logic current_limit_lock,
    output logic [3:0] bridge_mode,
    output logic fault_indicator_pin_n,
    output logic irq
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] motor_lock_fault_settings;
    logic [31:0] next_settings;
    logic [3:0] status;
    logic [3:0] next_status;
    logic [3:0] irq_en;
    logic [3:0] next_irq_en;
    logic [31:0] next_rdata;
    logic [3:0] events;
    logic overspeed_lock_enable;
    logic backemf_lock_enable;
    logic no_load_lock_enable;
    logic [3:0] current_limit_lock_response;
    logic [2:0] current_limit_lock_filter;

    assign overspeed_lock_enable = motor_lock_fault_settings[`MLFC_BIT_OVERSPEED_EN];
    assign backemf_lock_enable = motor_lock_fault_settings[`MLFC_BIT_BACKEMF_EN];
    assign no_load_lock_enable = motor_lock_fault_settings[`MLFC_BIT_NO_LOAD_EN];
    assign current_limit_lock_response = motor_lock_fault_settings[`MLFC_ILIM_MODE_HI:`MLFC_ILIM_MODE_LO];
    assign current_limit_lock_filter = motor_lock_fault_settings[`MLFC_ILIM_FILT_HI:`MLFC_ILIM_FILT_LO];

    always_comb begin
        next_settings = motor_lock_fault_settings;
        next_irq_en = irq_en;
        // Set wins over a clear in the same cycle
        next_status = status | events;
        if (wr && addr == `MLFC_OFF_SETTINGS) begin
            // Bit 11 stays reserved zero; all other bits including 31 are storage
            next_settings = wdata & `MLFC_SETTINGS_WMASK;
        end
        if (wr && addr == `MLFC_OFF_IRQ_EN) begin
            next_irq_en = wdata[3:0];
        end
        if (wr && addr == `MLFC_OFF_CLEAR) begin
            next_status = (status & ~wdata[3:0]) | events;
        end
        next_rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                `MLFC_OFF_SETTINGS: next_rdata = motor_lock_fault_settings;
                `MLFC_OFF_STATUS: next_rdata = {28'h000_0000, status};
                `MLFC_OFF_IRQ_EN: next_rdata = {28'h000_0000, irq_en};
                `MLFC_OFF_LIVE: next_rdata = {28'h000_0000, current_limit_lock, no_load_lock,
                    backemf_lock, overspeed_lock};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            motor_lock_fault_settings <= `MLFC_SETTINGS_RESET;
            status <= 4'h0;
            irq_en <= 4'h0;
            rdata <= 32'h0000_0000;
        end else begin
            motor_lock_fault_settings <= next_settings;
            status <= next_status;
            irq_en <= next_irq_en;
            rdata <= next_rdata;
        end
    end

    assign irq = |(status & irq_en);

    // ------------------------------------------------------------
    // Trip level selects to the detector front ends
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            overspeed_trip_level <= 3'h0;
            backemf_trip_level <= 3'h0;
            no_load_current_level <= 3'h0;
        end else begin
            overspeed_trip_level <= next_settings[`MLFC_OVERSPEED_HI:`MLFC_OVERSPEED_LO];
            backemf_trip_level <= next_settings[`MLFC_BACKEMF_HI:`MLFC_BACKEMF_LO];
            no_load_current_level <= next_settings[`MLFC_NO_LOAD_HI:`MLFC_NO_LOAD_LO];
        end
    end

    // ------------------------------------------------------------
    // Armed lock detectors
    // ------------------------------------------------------------
    mlfc_detector_gate u_overspeed (
        .clk(clk),
        .srst(srst),
        .enable(overspeed_lock_enable),
        .raw_trip(overspeed_trip),
        .fault(overspeed_lock),
        .event_pulse(events[0])
    );
    mlfc_detector_gate u_backemf (
        .clk(clk),
        .srst(srst),
        .enable(backemf_lock_enable),
        .raw_trip(backemf_trip),
        .fault(backemf_lock),
        .event_pulse(events[1])
    );
    mlfc_detector_gate u_no_load (
        .clk(clk),
        .srst(srst),
        .enable(no_load_lock_enable),
        .raw_trip(no_load_trip),
        .fault(no_load_lock),
        .event_pulse(events[2])
    );

    // ------------------------------------------------------------
    // Current-limit lock: filter, latch, bridge response
    // ------------------------------------------------------------
    mlfc_pkg::mlfc_ilim_state_t ilim_state;
    mlfc_pkg::mlfc_ilim_state_t next_ilim_state;
    logic [`MLFC_FILT_CNT_W-1:0] filt_cnt;
    logic [`MLFC_FILT_CNT_W-1:0] next_filt_cnt;
    logic [`MLFC_FILT_CNT_W-1:0] filt_target;
    logic ilim_armed;
    logic [3:0] next_bridge_mode;

    // Codes 4..7 retry modes are handled as latched here; retry timing is outside this block
    assign ilim_armed = (current_limit_lock_response != `MLFC_ILIM_MODE_OFF) &&
        !current_limit_lock_response[3];
    assign filt_target = `MLFC_FILT_CNT_W'(current_limit_lock_filter * `MLFC_FILT_STEP_CYC);

    always_comb begin
        next_ilim_state = ilim_state;
        next_filt_cnt = filt_cnt;
        case (ilim_state)
            mlfc_pkg::MLFC_ST_RUN: begin
                next_filt_cnt = '0;
                if (ilim_armed && current_limit_hit) begin
                    if (current_limit_lock_filter == 3'h0) begin
                        next_ilim_state = mlfc_pkg::MLFC_ST_LATCHED;
                    end else begin
                        next_ilim_state = mlfc_pkg::MLFC_ST_FILTER;
                        next_filt_cnt = `MLFC_FILT_CNT_W'(1);
                    end
                end
            end
            mlfc_pkg::MLFC_ST_FILTER: begin
                if (!ilim_armed || !current_limit_hit) begin
                    next_ilim_state = mlfc_pkg::MLFC_ST_RUN;
                    next_filt_cnt = '0;
                end else if (filt_cnt >= filt_target) begin
                    next_ilim_state = mlfc_pkg::MLFC_ST_LATCHED;
                end else begin
                    next_filt_cnt = filt_cnt + `MLFC_FILT_CNT_W'(1);
                end
            end
            mlfc_pkg::MLFC_ST_LATCHED: begin
                // Latched until released, or dropped at once if detection is switched off
                if (!ilim_armed || current_limit_release) begin
                    next_ilim_state = mlfc_pkg::MLFC_ST_RUN;
                end
            end
            default: next_ilim_state = mlfc_pkg::MLFC_ST_RUN;
        endcase
        case (current_limit_lock_response[1:0])
            2'd0: next_bridge_mode = mlfc_pkg::MLFC_BRIDGE_TRISTATE;
            2'd1: next_bridge_mode = mlfc_pkg::MLFC_BRIDGE_RECIRC;
            2'd2: next_bridge_mode = mlfc_pkg::MLFC_BRIDGE_HS_BRAKE;
            default: next_bridge_mode = mlfc_pkg::MLFC_BRIDGE_LS_BRAKE;
        endcase
        if (next_ilim_state != mlfc_pkg::MLFC_ST_LATCHED) begin
            next_bridge_mode = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ilim_state <= mlfc_pkg::MLFC_ST_RUN;
            filt_cnt <= '0;
            bridge_mode <= 4'h0;
        end else begin
            ilim_state <= next_ilim_state;
            filt_cnt <= next_filt_cnt;
            bridge_mode <= next_bridge_mode;
        end
    end

    assign current_limit_lock = (ilim_state == mlfc_pkg::MLFC_ST_LATCHED);
    assign events[3] = (next_ilim_state == mlfc_pkg::MLFC_ST_LATCHED) && !current_limit_lock;
    assign fault_indicator_pin_n = ~(current_limit_lock | overspeed_lock | backemf_lock | no_load_lock);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_write_settings;
        wr && addr == `MLFC_OFF_SETTINGS;
    endsequence
    sequence s_read_settings;
        rd && addr == `MLFC_OFF_SETTINGS;
    endsequence

    property p_reset_zero;
        @(posedge clk) srst |=> motor_lock_fault_settings == 32'h0000_0000 && bridge_mode == 4'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("settings not zero after reset");

    property p_write_read;
        @(posedge clk) disable iff (srst)
            s_write_settings ##1 (s_read_settings and !wr) |=> rdata == ($past(wdata, 2) & `MLFC_SETTINGS_WMASK);
    endproperty
    a_write_read: assert property (p_write_read) else $error("settings readback mismatch");

    property p_overspeed_armed;
        @(posedge clk) disable iff (srst) overspeed_lock_enable && overspeed_trip |=> overspeed_lock;
    endproperty
    a_overspeed_armed: assert property (p_overspeed_armed) else $error("overspeed lock missed");

    property p_backemf_armed;
        @(posedge clk) disable iff (srst) backemf_lock_enable && backemf_trip |=> backemf_lock;
    endproperty
    a_backemf_armed: assert property (p_backemf_armed) else $error("back-EMF lock missed");

    property p_no_load_armed;
        @(posedge clk) disable iff (srst) no_load_lock_enable && no_load_trip |=> no_load_lock;
    endproperty
    a_no_load_armed: assert property (p_no_load_armed) else $error("no-load lock missed");

    property p_levels;
        @(posedge clk) disable iff (srst) s_write_settings |=>
            overspeed_trip_level == $past(wdata[27:25]) && backemf_trip_level == $past(wdata[24:22])
            && no_load_current_level == $past(wdata[21:19]);
    endproperty
    a_levels: assert property (p_levels) else $error("trip levels not updated");

    property p_off_code;
        @(posedge clk) disable iff (srst) current_limit_lock_response == `MLFC_ILIM_MODE_OFF |=> !current_limit_lock;
    endproperty
    a_off_code: assert property (p_off_code) else $error("current-limit lock while disabled");

    property p_no_filter;
        @(posedge clk) disable iff (srst)
            ilim_state == mlfc_pkg::MLFC_ST_RUN && ilim_armed && current_limit_hit && current_limit_lock_filter == 3'h0
            |=> current_limit_lock && !fault_indicator_pin_n;
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("unfiltered lock not immediate");

    property p_filter_hold;
        @(posedge clk) disable iff (srst)
            $rose(ilim_state == mlfc_pkg::MLFC_ST_FILTER) |-> !current_limit_lock [*8];
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("filtered lock too early");
endmodule : mlfc_lock_config
`default_nettype wire

// ### testbench/tb.sv
// Self-checking testbench of the lock-fault configuration block
`timescale 1ns/1ps
`default_nettype none
`include "mlfc_defines.svh"
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] trip = 3'h0;
    logic hit = 1'b0;
    logic release_cl = 1'b0;
    logic [31:0] rdata;
    logic [2:0] os_lvl, be_lvl, nl_lvl;
    logic [2:0] locks;
    logic cl_lock, pin_n, irq;
    logic [3:0] bridge_mode;
    logic [31:0] v;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    mlfc_lock_config i_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .overspeed_trip(trip[0]), .backemf_trip(trip[1]), .no_load_trip(trip[2]),
        .current_limit_hit(hit), .current_limit_release(release_cl), .overspeed_trip_level(os_lvl),
        .backemf_trip_level(be_lvl), .no_load_current_level(nl_lvl), .overspeed_lock(locks[0]),
        .backemf_lock(locks[1]), .no_load_lock(locks[2]), .current_limit_lock(cl_lock),
        .bridge_mode(bridge_mode), .fault_indicator_pin_n(pin_n), .irq(irq));

    always #12.5 clk = ~clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        r = rdata;
    endtask : wr_rd

    task automatic wait_lock(input int mx, output int cnt);
        cnt = 0;
        while (cl_lock !== 1'b1 && cnt < mx) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask : wait_lock

    task automatic drop_cl();
        @(posedge clk);
        hit <= 1'b0;
        release_cl <= 1'b1;
        @(posedge clk);
        release_cl <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({27'h0, cl_lock, bridge_mode}, 32'h0000_0000);
    endtask : drop_cl

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        rd_reg(`MLFC_OFF_SETTINGS, v);
        chk(v, 32'h0000_0000);
        chk({15'h0, os_lvl, be_lvl, nl_lvl, locks, cl_lock, bridge_mode}, 32'h0000_0000);
        chk({30'h0, pin_n, irq}, 32'h0000_0002);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_fields();
        logic [31:0] d;
        wr_rd(`MLFC_OFF_SETTINGS, 32'hFFFF_FFFF, v);
        chk(v, 32'hFFFF_F7FF);
        for (int c = 0; c < 8; c++) begin
            d = (32'(c) << 25) | (32'(7 - c) << 22) | (32'(c) << 19) | (32'h8 << 15);
            wr_rd(`MLFC_OFF_SETTINGS, d, v);
            chk(v, d);
            chk({29'h0, os_lvl}, 32'(c));
            chk({29'h0, be_lvl}, 32'(7 - c));
            chk({29'h0, nl_lvl}, 32'(c));
        end
        $display("test_fields done");
    endtask : test_fields

    task automatic test_detectors();
        wr_reg(`MLFC_OFF_IRQ_EN, 32'h0000_000F);
        for (int k = 0; k < 3; k++) begin
            wr_reg(`MLFC_OFF_SETTINGS, 32'h0E00_0000);
            @(posedge clk);
            trip[k] <= 1'b1;
            repeat (4) @(posedge clk);
            #1;
            chk({28'h0, pin_n, locks}, 32'h0000_0008);
            rd_reg(`MLFC_OFF_STATUS, v);
            chk(v, 32'h0000_0000);
            wr_reg(`MLFC_OFF_SETTINGS, 32'h0000_0001 << (30 - k));
            repeat (2) @(posedge clk);
            #1;
            chk({28'h0, pin_n, locks}, 32'(1 << k));
            rd_reg(`MLFC_OFF_STATUS, v);
            chk(v, 32'(1 << k));
            chk({31'h0, irq}, 32'h0000_0001);
            @(posedge clk);
            trip[k] <= 1'b0;
            wr_reg(`MLFC_OFF_CLEAR, 32'(1 << k));
            rd_reg(`MLFC_OFF_STATUS, v);
            chk(v, 32'h0000_0000);
            chk({30'h0, irq, pin_n}, 32'h0000_0001);
        end
        $display("test_detectors done");
    endtask : test_detectors

    task automatic test_current_limit();
        for (int m = 0; m < 4; m++) begin
            wr_reg(`MLFC_OFF_SETTINGS, 32'(m) << 15);
            @(posedge clk);
            hit <= 1'b1;
            wait_lock(4, n);
            chk({27'h0, pin_n, bridge_mode}, 32'(1 << m));
            rd_reg(`MLFC_OFF_LIVE, v);
            chk(v, 32'h0000_0008);
            drop_cl();
        end
        wr_reg(`MLFC_OFF_SETTINGS, 32'h0004_0000);
        @(posedge clk);
        hit <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk({27'h0, cl_lock, bridge_mode}, 32'h0000_0000);
        drop_cl();
        // Three-step filter: a short burst must not lock, a held hit must
        wr_reg(`MLFC_OFF_SETTINGS, 32'h0000_3000);
        @(posedge clk);
        hit <= 1'b1;
        repeat (60) @(posedge clk);
        #1;
        chk({31'h0, cl_lock}, 32'h0000_0000);
        @(posedge clk);
        hit <= 1'b0;
        @(posedge clk);
        hit <= 1'b1;
        wait_lock(200, n);
        chk({31'h0, n >= 100 && n <= 140}, 32'h0000_0001);
        drop_cl();
        // Current-limit event is sticky and still enabled onto the interrupt
        rd_reg(`MLFC_OFF_STATUS, v);
        chk(v, 32'h0000_0008);
        chk({31'h0, irq}, 32'h0000_0001);
        rd_reg(`MLFC_OFF_IRQ_EN, v);
        chk(v, 32'h0000_000F);
        $display("test_current_limit done");
    endtask : test_current_limit

    task automatic test_unmapped();
        wr_reg(`MLFC_OFF_SETTINGS, 32'h5555_5555);
        wr_reg(8'hA1, 32'hFFFF_FFFF);
        rd_reg(8'hA1, v);
        chk(v, 32'h0000_0000);
        rd_reg(`MLFC_OFF_SETTINGS, v);
        chk(v, 32'h5555_5555);
        $display("test_unmapped done");
    endtask : test_unmapped

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        test_reset();
        test_fields();
        test_detectors();
        test_current_limit();
        test_unmapped();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
